// [logic/sbsp_defines.vh]
// constants and register map of the synchronous burst sram port
`ifndef SBSP_DEFINES_VH
`define SBSP_DEFINES_VH

`define SBSP_APB_AW 8
`define SBSP_OFF_CTRL 8'h00
`define SBSP_OFF_STATUS 8'h04
`define SBSP_OFF_ERRCNT 8'h08

`define SBSP_CTRL_ODD_BIT 0
`define SBSP_STAT_PERR_BIT 0
`define SBSP_STAT_SLEEP_BIT 1
`define SBSP_STAT_MODE_LSB 2

`define SBSP_CTRL_RST 1'h0
`define SBSP_ERRCNT_W 16

`define SBSP_SYNC_STAGES 3
`define SBSP_NUM_PINS 5
`define SBSP_PIN_FT_N 0
`define SBSP_PIN_LIN_N 1
`define SBSP_PIN_SCD 2
`define SBSP_PIN_PAR_N 3
`define SBSP_PIN_SLEEP 4
`define SBSP_PIN_RST 5'h0F

`define SBSP_LANE_W 9

`endif

// [logic/sbsp_burst_counter.v]
// two-bit burst address counter with linear and interleaved order
`timescale 1ns/100ps
`default_nettype none
module sbsp_burst_counter (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [1:0] base,
    input wire advance,
    input wire linear_order_sel_n,
    output wire [1:0] step_low
);
    reg [1:0] base_reg;
    reg [1:0] cnt_reg;
    wire [1:0] cnt_eff;

    assign cnt_eff = cnt_reg + {1'b0, advance};
    assign step_low = load ? base :
        (~linear_order_sel_n ? base_reg + cnt_eff : base_reg ^ cnt_eff);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_reg <= 2'h0;
            cnt_reg <= 2'h0;
        end else if (load) begin
            base_reg <= base;
            cnt_reg <= 2'h0;
        end else if (advance) begin
            cnt_reg <= cnt_eff;
        end
    end
endmodule
`default_nettype wire

// [logic/sbsp_sram_port.v]
// synchronous burst sram port with apb status and control
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "sbsp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module sbsp_sram_port #(
    parameter ADDR_W = 18,
    parameter BYTES = 4
) (
    input wire pclk,
    input wire presetn,
    input wire [`SBSP_APB_AW-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [ADDR_W-3:0] addr_high,
    input wire addr_bit_one,
    input wire addr_bit_zero,
    input wire chip_sel_a_n,
    input wire chip_sel_b,
    input wire chip_sel_c_n,
    input wire proc_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_advance_n,
    input wire byte_write_en_n,
    input wire global_write_n,
    input wire [BYTES-1:0] byte_select_n,
    input wire output_enable_n,
    input wire sleep_request,
    input wire flow_through_sel_n,
    input wire linear_order_sel_n,
    input wire deselect_mode_sel,
    input wire parity_check_en_n,
    input wire [8*BYTES-1:0] dq_in,
    output wire [8*BYTES-1:0] dq_out,
    output wire dq_oe,
    input wire [BYTES-1:0] parity_lane_in,
    output wire [BYTES-1:0] parity_lane_out,
    output wire parity_lane_oe
);
    localparam DEPTH = 1 << ADDR_W;
    localparam LW = `SBSP_LANE_W;
    localparam NP = `SBSP_NUM_PINS;
    localparam [NP-1:0] PIN_RST = `SBSP_PIN_RST;

    // mode and sleep pins: three-stage synchronisers
    wire [NP-1:0] pin_raw;
    reg [NP-1:0] pin_s1_reg;
    reg [NP-1:0] pin_s2_reg;
    reg [NP-1:0] pin_s3_reg;
    reg [NP-1:0] pin_val_reg;

    assign pin_raw[`SBSP_PIN_FT_N] = flow_through_sel_n;
    assign pin_raw[`SBSP_PIN_LIN_N] = linear_order_sel_n;
    assign pin_raw[`SBSP_PIN_SCD] = deselect_mode_sel;
    assign pin_raw[`SBSP_PIN_PAR_N] = parity_check_en_n;
    assign pin_raw[`SBSP_PIN_SLEEP] = sleep_request;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp = gp + 1) begin : g_pin
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_s1_reg[gp] <= PIN_RST[gp];
                    pin_s2_reg[gp] <= PIN_RST[gp];
                    pin_s3_reg[gp] <= PIN_RST[gp];
                    pin_val_reg[gp] <= PIN_RST[gp];
                end else begin
                    pin_s1_reg[gp] <= pin_raw[gp];
                    pin_s2_reg[gp] <= pin_s1_reg[gp];
                    pin_s3_reg[gp] <= pin_s2_reg[gp];
                    if (pin_s2_reg[gp] == pin_s3_reg[gp]) begin
                        pin_val_reg[gp] <= pin_s3_reg[gp];
                    end
                end
            end
        end
    endgenerate

    wire ft_mode;
    wire lin_n;
    wire scd_mode;
    wire par_en;
    wire asleep;

    assign ft_mode = ~pin_val_reg[`SBSP_PIN_FT_N];
    assign lin_n = pin_val_reg[`SBSP_PIN_LIN_N];
    assign scd_mode = pin_val_reg[`SBSP_PIN_SCD];
    assign par_en = ~pin_val_reg[`SBSP_PIN_PAR_N];
    assign asleep = pin_val_reg[`SBSP_PIN_SLEEP];

    // command decode directly on the unregistered bus control inputs
    wire selected;
    wire strobe;
    wire load;
    wire desel;
    wire advance;
    wire cycle;
    wire [BYTES-1:0] wmask;
    wire wr_any;
    reg active_reg;

    assign selected = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
    assign strobe = (~proc_addr_strobe_n | ~ctrl_addr_strobe_n) & ~asleep;
    assign load = strobe & selected;
    assign desel = strobe & ~selected;
    assign advance = ~burst_advance_n & ~strobe & active_reg & ~asleep;
    assign cycle = load | (active_reg & ~strobe & ~asleep);
    assign wmask = ~global_write_n ? {BYTES{1'b1}} :
        (~byte_write_en_n ? ~byte_select_n : {BYTES{1'b0}});
    assign wr_any = |wmask;

    // burst address
    reg [ADDR_W-3:0] high_reg;
    wire [1:0] step_low;
    wire [ADDR_W-1:0] cur_addr;

    sbsp_burst_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .load(load),
        .base({addr_bit_one, addr_bit_zero}),
        .advance(advance),
        .linear_order_sel_n(lin_n),
        .step_low(step_low)
    );

    assign cur_addr = {(load ? addr_high : high_reg), step_low};

    // pipeline of read and deselect commands
    reg [ADDR_W-1:0] addr_reg;
    reg rd_reg;
    reg desel_reg;
    reg pipe_rd_reg;
    reg [LW*BYTES-1:0] pipe_data_reg;
    wire [LW*BYTES-1:0] array_rd;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_reg <= {(ADDR_W-2){1'b0}};
            addr_reg <= {ADDR_W{1'b0}};
            active_reg <= 1'b0;
            rd_reg <= 1'b0;
            desel_reg <= 1'b0;
            pipe_rd_reg <= 1'b0;
            pipe_data_reg <= {(LW*BYTES){1'b0}};
        end else begin
            if (load) begin
                high_reg <= addr_high;
                active_reg <= 1'b1;
            end else if (desel) begin
                active_reg <= 1'b0;
            end
            if (cycle) begin
                addr_reg <= cur_addr;
            end
            rd_reg <= cycle & ~wr_any;
            desel_reg <= desel;
            pipe_rd_reg <= rd_reg & ~(scd_mode & desel_reg);
            pipe_data_reg <= array_rd;
        end
    end

    // array: one memory per byte lane, parity bit on top
    genvar gl;
    generate
        for (gl = 0; gl < BYTES; gl = gl + 1) begin : g_lane
            reg [LW-1:0] lane_mem [0:DEPTH-1];
            always @(posedge pclk) begin
                if (cycle && wmask[gl]) begin
                    lane_mem[cur_addr] <= {parity_lane_in[gl], dq_in[8*gl+7:8*gl]};
                end
            end
            assign array_rd[LW*gl+LW-1:LW*gl] = lane_mem[addr_reg];
        end
    endgenerate

    // output path
    wire [LW*BYTES-1:0] shown;
    wire show_valid;
    wire drive;

    assign shown = ft_mode ? array_rd : pipe_data_reg;
    assign show_valid = ft_mode ? rd_reg : pipe_rd_reg;
    assign drive = ft_mode ? rd_reg :
        (pipe_rd_reg & ~(scd_mode & desel_reg));
    assign dq_oe = drive & ~output_enable_n & ~sleep_request;
    assign parity_lane_oe = dq_oe;

    genvar go;
    generate
        for (go = 0; go < BYTES; go = go + 1) begin : g_out
            assign dq_out[8*go+7:8*go] = shown[LW*go+7:LW*go];
            assign parity_lane_out[go] = shown[LW*go+8];
        end
    endgenerate

    // read parity check
    reg odd_reg;
    wire [BYTES-1:0] lane_bad;
    wire perr_event;

    genvar gc;
    generate
        for (gc = 0; gc < BYTES; gc = gc + 1) begin : g_par
            assign lane_bad[gc] = (^shown[LW*gc+LW-1:LW*gc]) ^ odd_reg;
        end
    endgenerate

    assign perr_event = show_valid & par_en & (|lane_bad);

    // apb slave
    reg perr_reg;
    reg [`SBSP_ERRCNT_W-1:0] errcnt_reg;
    wire apb_access;
    wire apb_commit;
    wire apb_hit;
    reg [31:0] rd_mux;

    assign apb_access = psel & penable;
    assign apb_commit = apb_access & pready;
    assign apb_hit = (paddr == `SBSP_OFF_CTRL) | (paddr == `SBSP_OFF_STATUS) |
        (paddr == `SBSP_OFF_ERRCNT);

    always @* begin
        rd_mux = 32'h0;
        case (paddr)
            `SBSP_OFF_CTRL: begin
                rd_mux[`SBSP_CTRL_ODD_BIT] = odd_reg;
            end
            `SBSP_OFF_STATUS: begin
                rd_mux[`SBSP_STAT_PERR_BIT] = perr_reg;
                rd_mux[`SBSP_STAT_SLEEP_BIT] = asleep;
                rd_mux[`SBSP_STAT_MODE_LSB+2:`SBSP_STAT_MODE_LSB] =
                    pin_val_reg[`SBSP_PIN_SCD:`SBSP_PIN_FT_N];
            end
            `SBSP_OFF_ERRCNT: begin
                rd_mux[`SBSP_ERRCNT_W-1:0] = errcnt_reg;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (apb_access && !pready) begin
            pready <= 1'b1;
            pslverr <= ~apb_hit;
            prdata <= pwrite ? 32'h0 : rd_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odd_reg <= `SBSP_CTRL_RST;
            perr_reg <= 1'b0;
            errcnt_reg <= {`SBSP_ERRCNT_W{1'b0}};
        end else begin
            if (apb_commit && pwrite && paddr == `SBSP_OFF_CTRL) begin
                odd_reg <= pwdata[`SBSP_CTRL_ODD_BIT];
            end
            // a new error wins over a write-one clear in the same cycle
            if (perr_event) begin
                perr_reg <= 1'b1;
            end else if (apb_commit && pwrite && paddr == `SBSP_OFF_STATUS &&
                    pwdata[`SBSP_STAT_PERR_BIT]) begin
                perr_reg <= 1'b0;
            end
            if (perr_event && errcnt_reg != {`SBSP_ERRCNT_W{1'b1}}) begin
                errcnt_reg <= errcnt_reg + {{(`SBSP_ERRCNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// [test/sbsp_sram_port_assertions.sv]
// concurrent checks on the pins of the burst sram port
`timescale 1ns/100ps
`default_nettype none
module sbsp_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic byte_write_en_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic flow_through_sel_n,
    input wire logic deselect_mode_sel,
    input wire logic dq_oe,
    input wire logic parity_lane_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire stb = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    wire cs_on = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    wire rd = stb && cs_on && global_write_n && byte_write_en_n && !sleep_request;
    wire dsl = stb && !cs_on && !sleep_request;
    wire quiet = !output_enable_n && !sleep_request;
    sequence s_pp_rd;
        rd && flow_through_sel_n;
    endsequence
    sequence s_dual_dsl;
        dsl && !deselect_mode_sel;
    endsequence
    property p_apb_ans;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
    property p_oe_gate;
        output_enable_n || sleep_request |-> !dq_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("drive while gated");
    property p_par_oe;
        parity_lane_oe == dq_oe;
    endproperty
    a_par_oe: assert property (p_par_oe) else $error("parity lane drive differs");
    property p_ft_rd;
        rd && quiet && !flow_through_sel_n |=> !quiet || dq_oe;
    endproperty
    a_ft_rd: assert property (p_ft_rd) else $error("flow read not driven");
    property p_pp_rd;
        s_pp_rd ##1 (global_write_n && byte_write_en_n && !dsl) |=> !quiet || dq_oe;
    endproperty
    a_pp_rd: assert property (p_pp_rd) else $error("piped read not driven");
    property p_scd_off;
        dsl && deselect_mode_sel |=> !dq_oe;
    endproperty
    a_scd_off: assert property (p_scd_off) else $error("single deselect late");
    property p_dcd_hold;
        s_pp_rd ##1 s_dual_dsl |=> !quiet || dq_oe;
    endproperty
    a_dcd_hold: assert property (p_dcd_hold) else $error("dual deselect early");
    property p_dcd_off;
        s_dual_dsl ##1 !stb |=> !dq_oe;
    endproperty
    a_dcd_off: assert property (p_dcd_off) else $error("dual deselect late");
endmodule
`default_nettype wire

// [test/sbsp_host_model.sv]
// host controller model that issues commands on the sram pins
`timescale 1ns/100ps
`default_nettype none
module sbsp_host (
    input wire logic pclk,
    output logic [15:0] addr_high,
    output logic addr_bit_one,
    output logic addr_bit_zero,
    output logic chip_sel_a_n,
    output logic chip_sel_b,
    output logic chip_sel_c_n,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_advance_n,
    output logic byte_write_en_n,
    output logic global_write_n,
    output logic [3:0] byte_select_n,
    output logic output_enable_n,
    output logic [31:0] host_dq,
    output logic [3:0] host_par
);
    logic bad = 1'b0;
    initial begin
        {addr_high, addr_bit_one, addr_bit_zero, host_dq, host_par, output_enable_n} = '0;
        {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 3'b010;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'b111;
        {byte_write_en_n, global_write_n, byte_select_n} = 6'h3F;
    end
    // k: 0 hold, 1 load by controller strobe, 2 load by processor strobe, 3 advance, 4 deselect
    task automatic cyc(input int k, input logic [17:0] a, input logic [3:0] wm,
        input logic [31:0] d, input logic g);
        @(posedge pclk);
        {addr_high, addr_bit_one, addr_bit_zero} <= a;
        ctrl_addr_strobe_n <= !(k == 1 || k == 4);
        proc_addr_strobe_n <= (k != 2);
        chip_sel_b <= (k != 4);
        burst_advance_n <= (k != 3);
        global_write_n <= (wm != 4'hF);
        byte_write_en_n <= (wm == 4'h0 || wm == 4'hF);
        byte_select_n <= ~wm;
        output_enable_n <= g;
        // released lines toggle so a stale value never passes for read data
        host_dq <= (wm == 4'h0) ? ~host_dq : d;
        host_par <= (wm == 4'h0) ? ~host_par :
            {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{bad}};
    endtask
endmodule
`default_nettype wire

// [test/sbsp_sram_port_test.sv]
// self-checking bench for the synchronous burst sram port
`timescale 1ns/100ps
`default_nettype none
module sbsp_sram_port_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv, dq_in, dq_out, host_dq, d1, d2;
    logic pready, pslverr, dq_oe, parity_lane_oe, output_enable_n, act = 0, e1 = 0, e2 = 0;
    logic sleep_request = 0, flow_through_sel_n = 1, linear_order_sel_n = 1;
    logic deselect_mode_sel = 1, parity_check_en_n = 0;
    logic [15:0] addr_high;
    logic addr_bit_one, addr_bit_zero, chip_sel_a_n, chip_sel_b, chip_sel_c_n;
    logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, byte_write_en_n;
    logic global_write_n;
    logic [3:0] byte_select_n, parity_lane_in, parity_lane_out, host_par;
    logic [17:0] a, base;
    logic [31:0] mem [int];
    logic [3:0] pm [int];
    logic [3:0] p1, p2;
    int fail_count = 0, n_compared = 0, seed = 19, cyc_n = 0, k = 0;
    assign dq_in = dq_oe ? dq_out : host_dq;
    assign parity_lane_in = parity_lane_oe ? parity_lane_out : host_par;
    sbsp_sram_port dut (.*);
    sbsp_host u_host (.*);
    initial forever #20 pclk = ~pclk;
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_one(input logic [17:0] ad);
        u_host.cyc(1, ad, 4'h0, 0, 0);
        u_host.cyc(0, ad, 4'h0, 0, 0);
        u_host.cyc(4, ad, 4'h0, 0, 0);
        u_host.cyc(0, ad, 4'h0, 0, 0);
    endtask
    function automatic logic [1:0] ord(logic [1:0] b, logic [1:0] n, logic lin_n);
        return lin_n ? b ^ n : b + n;
    endfunction
    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] m);
        for (int b = 0; b < 4; b++)
            if (m[b]) o[8*b+:8] = n[8*b+:8];
        return o;
    endfunction
    always @(posedge pclk) begin : sb
        logic stb, on, go;
        logic [3:0] wm;
        logic [17:0] ad;
        stb = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
        on = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
        wm = !global_write_n ? 4'hF : byte_write_en_n ? 4'h0 : ~byte_select_n;
        go = stb && on || !stb && act;
        if (stb && on) begin
            base = {addr_high, addr_bit_one, addr_bit_zero};
            k = 0;
        end else if (act && !stb)
            k = k + !burst_advance_n;
        act = presetn && (stb ? on : act);
        ad = {base[17:2], ord(base[1:0], k[1:0], linear_order_sel_n)};
        if (go && wm != 4'h0) begin
            mem[ad] = mrg(mem[ad], dq_in, wm);
            pm[ad] = (pm.exists(ad) ? pm[ad] : 4'h0) & ~wm | parity_lane_in & wm;
        end
        e1 <= go && wm == 4'h0 && mem.exists(ad);
        d1 <= mem.exists(ad) ? mem[ad] : 32'h0;
        p1 <= pm.exists(ad) ? pm[ad] : 4'h0;
        e2 <= e1 && !(stb && !on && deselect_mode_sel);
        d2 <= d1;
        p2 <= p1;
        if ((flow_through_sel_n ? e2 : e1) && !output_enable_n) begin
            chk(dq_out, flow_through_sel_n ? d2 : d1, "read data");
            chk(32'(parity_lane_out), 32'(flow_through_sel_n ? p2 : p1), "read parity");
            chk(32'(dq_oe), 32'h1, "read drive");
        end
        cyc_n++;
        if (cyc_n == 5000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, 8'h00, 0);
        chk(rdv, 32'h0, "ctrl reset");
        apb(1, 8'h00, 1);
        apb(0, 8'h00, 0);
        chk(rdv, 32'h1, "ctrl rw");
        apb(1, 8'h00, 0);
        apb(0, 8'h0C, 0);
        chk(32'(rerr), 32'h1, "unmapped");
        apb(0, 8'h04, 0);
        chk(32'(rdv[4:2]), 32'h7, "mode status");
        for (int m = 0; m < 8; m++) begin
            @(posedge pclk);
            {deselect_mode_sel, linear_order_sel_n, flow_through_sel_n} <= m[2:0];
            repeat (6) @(posedge pclk);
            a = 18'($random(seed)) & 18'h3FFFC;
            u_host.cyc(1 + m % 2, a, 4'hF, $random(seed), 0);
            for (int i = 0; i < 4; i++)
                u_host.cyc(3, a, (i == 3) ? 4'h6 : 4'hF, $random(seed), 0);
            u_host.cyc(4, a, 4'h0, 0, 0);
            u_host.cyc(2 - m % 2, a | 18'($random(seed) & 3), 4'h0, 0, 0);
            repeat (6) u_host.cyc(($random(seed) & 1) ? 3 : 0, a, 4'h0, 0, $random(seed) & 1);
            for (int i = 0; i < 4; i++)
                u_host.cyc(1 + i % 2, a + 18'(i), 4'h0, 0, 0);
            u_host.cyc(4, a, 4'h0, 0, 0);
            u_host.cyc(0, a, 4'h0, 0, 0);
        end
        @(posedge pclk);
        sleep_request <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, 8'h04, 0);
        chk(32'(rdv[1]), 32'h1, "asleep");
        sleep_request <= 1'b0;
        repeat (8) @(posedge pclk);
        rd_one(a);
        u_host.bad = 1'b1;
        u_host.cyc(1, a ^ 18'h4, 4'hF, 32'hA5, 0);
        u_host.bad = 1'b0;
        u_host.cyc(4, a, 4'h0, 0, 0);
        rd_one(a ^ 18'h4);
        apb(0, 8'h04, 0);
        chk(32'(rdv[0]), 32'h1, "parity flag");
        apb(0, 8'h08, 0);
        chk(32'(rdv == 0), 32'h0, "error count");
        apb(1, 8'h04, 1);
        apb(0, 8'h04, 0);
        chk(32'(rdv[0]), 32'h0, "flag clear");
        test_done();
    end
endmodule
bind sbsp_sram_port sbsp_chk u_chk (.*);
`default_nettype wire
